// *** dv/core_model.sv ***
// Core model: one cycle of load strobes (none, one or both) per call; call it just after a rising edge.
`timescale 1ns/1ps
module core_model import tmr_load_pkg::*; (
  input wire logic core_clk,
  output logic load_timer_and_first_reload = 1'h0,
  output logic load_second_reload = 1'h0,
  output logic [NIB_W-1:0] acc = 4'h0,
  output logic [NIB_W-1:0] reg_b = 4'h0
);
  task automatic issue(input logic a, b, input logic [NIB_W-1:0] x, y);
    {load_timer_and_first_reload, load_second_reload} <= {a, b};
    {acc, reg_b} <= {x, y};
    @(posedge core_clk);
  endtask
endmodule

// *** dv/tb.sv ***
// Bench: random loads through core_model, outputs checked from a queue.
`timescale 1ns/1ps
module tb import tmr_load_pkg::*;;
  logic core_clk = 1'h0, rst = 1'h1, clk_en = 1'h0, e, carry_write, skip_next;
  logic load_timer_and_first_reload, load_second_reload, load_done, ld = 1'h0;
  logic [NIB_W-1:0] acc, reg_b, av, bv;
  logic [DATA_W-1:0] timer_count, first_reload_value, second_reload_value;
  logic [3*DATA_W-1:0] m = 24'h0;
  logic [3*DATA_W+2:0] q[$], got;
  int n_errors = 0, tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  core_model core(
    .core_clk(core_clk),
    .load_timer_and_first_reload(load_timer_and_first_reload),
    .load_second_reload(load_second_reload),
    .acc(acc),
    .reg_b(reg_b)
  );
  timer1_reload_load_ops uut(
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .load_timer_and_first_reload(load_timer_and_first_reload),
    .load_second_reload(load_second_reload),
    .acc(acc),
    .reg_b(reg_b),
    .timer_count(timer_count),
    .first_reload_value(first_reload_value),
    .second_reload_value(second_reload_value),
    .carry_write(carry_write),
    .skip_next(skip_next),
    .load_done(load_done)
  );
  assign got = {timer_count, first_reload_value, second_reload_value,
    load_done, carry_write, skip_next};
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Expected state follows each enabled load; disabled cycles hold it
  task automatic step(input logic a, b);
    {av, bv, e} = 9'($urandom);
    clk_en <= e;
    core.issue(a, b, av, bv);
    if (e && a) m[23:8] = {2{bv, av}};
    if (e && b) m[7:0] = {bv, av};
    if (e) ld = a | b;
    q.push_back({m, ld, 2'h0});
  endtask
  // Checked at the falling edge so the loads have settled
  always @(negedge core_clk) if (q.size() > 0) begin
    tests_run++;
    if (got !== q[0]) begin
      n_errors++;
      $display("BAD outputs exp %h got %h", q[0], got);
    end
    void'(q.pop_front());
  end
  // Mid-run reset; the strobes are parked first so no load races it
  task automatic pulse_reset();
    clk_en <= 1'h0;
    core.issue(1'h0, 1'h0, 4'h0, 4'h0);
    rst <= 1'h1;
    m = '0;
    ld = 1'h0;
    q.push_back('0);
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
  endtask
  initial begin
    void'($urandom(38756));
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    for (int i = 0; i < 400; i++) begin
      if (i == 200) pulse_reset();
      step(1'($urandom), 1'($urandom));
    end
    #13 test_done();
  end
  // About half again the length of the full run
  initial begin
    #15000;
    n_errors++;
    test_done();
  end
endmodule

// *** rtl/timer1_reload_load_ops.sv ***
// Timer 1 count and reload registers, with their instruction load path.
// Assumes the core decodes instructions and pulses one strobe per load,
// with accumulator and B valid in that cycle, on the same clock.
`timescale 1ns/1ps

// Behaviour
// - Combined load copies acc into the low nibble of timer and reload 1.
// - Second reload load puts register B into its upper nibble.
// - Second reload load puts acc into its lower nibble, timer untouched.
// - Second reload load takes one cycle, leaves carry alone, never skips.
module timer1_reload_load_ops
  import tmr_load_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic load_timer_and_first_reload,
  input wire logic load_second_reload,
  input wire logic [NIB_W-1:0] acc,
  input wire logic [NIB_W-1:0] reg_b,
  output logic [DATA_W-1:0] timer_count,
  output logic [DATA_W-1:0] first_reload_value,
  output logic [DATA_W-1:0] second_reload_value,
  output logic carry_write,
  output logic skip_next,
  output logic load_done
);

  // ****************************************
  // Load decode
  // ****************************************
  logic [DATA_W-1:0] timer_ff;
  logic [DATA_W-1:0] reload1_ff;
  logic [DATA_W-1:0] reload2_ff;
  logic done_ff;
  wire logic [DATA_W-1:0] ab_word = {reg_b, acc};
  wire logic do_first = clk_en & load_timer_and_first_reload;
  wire logic do_second = clk_en & load_second_reload;
  wire logic [DATA_W-1:0] nxt_timer = do_first ? ab_word : timer_ff;
  wire logic [DATA_W-1:0] nxt_reload1 = do_first ? ab_word : reload1_ff;
  wire logic [DATA_W-1:0] nxt_reload2 = do_second ? ab_word : reload2_ff;

  // ****************************************
  // Registers
  // ****************************************
  // Both loads may coincide; they touch disjoint registers so no priority.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_ff <= RST_VALUE;
      reload1_ff <= RST_VALUE;
      reload2_ff <= RST_VALUE;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      timer_ff <= nxt_timer;
      reload1_ff <= nxt_reload1;
      reload2_ff <= nxt_reload2;
      done_ff <= do_first | do_second;
    end
  end

  assign timer_count = timer_ff;
  assign first_reload_value = reload1_ff;
  assign second_reload_value = reload2_ff;
  // Neither load ever writes carry or requests a skip
  assign carry_write = 1'b0;
  assign skip_next = 1'b0;
  assign load_done = done_ff;

  // ****************************************
  // Checks
  // ****************************************
  // Load events as the core presents them; a strobe with the enable low
  // is no event at all, since the core is stalled in that cycle.
  sequence first_load_s;
    clk_en && load_timer_and_first_reload;
  endsequence
  sequence second_load_s;
    clk_en && load_second_reload;
  endsequence
  sequence only_first_s;
    first_load_s and !load_second_reload;
  endsequence
  sequence only_second_s;
    second_load_s and !load_timer_and_first_reload;
  endsequence
  sequence both_loads_s;
    first_load_s and second_load_s;
  endsequence
  sequence second_twice_s;
    second_load_s ##1 second_load_s;
  endsequence
  sequence idle_enabled_s;
    clk_en && !load_timer_and_first_reload && !load_second_reload;
  endsequence

  // ****************************************
  // Combined load checks
  // ****************************************
  // Timer and first reload must leave the load as one identical word.
  a_first_low_nibble: assert property (
    @(posedge core_clk) disable iff (rst)
    first_load_s |=> timer_count[HI_LSB-1:0] == $past(acc)
      && first_reload_value[HI_LSB-1:0] == $past(acc))
    else $error("first load low nibble wrong");
  a_first_high_nibble: assert property (
    @(posedge core_clk) disable iff (rst)
    first_load_s |=> timer_count[DATA_W-1:HI_LSB] == $past(reg_b)
      && first_reload_value[DATA_W-1:HI_LSB] == $past(reg_b))
    else $error("first load high nibble wrong");
  a_first_pair_equal: assert property (
    @(posedge core_clk) disable iff (rst)
    first_load_s |=> timer_count == first_reload_value)
    else $error("timer and first reload differ after combined load");
  a_first_no_carry: assert property (
    @(posedge core_clk) disable iff (rst)
    first_load_s |=> !carry_write && load_done)
    else $error("combined load touched carry");
  a_first_no_skip: assert property (
    @(posedge core_clk) disable iff (rst)
    first_load_s |-> !skip_next ##1 !skip_next)
    else $error("combined load requested a skip");
  a_first_keeps_r2: assert property (
    @(posedge core_clk) disable iff (rst)
    only_first_s |=> $stable(second_reload_value))
    else $error("combined load changed the second reload value");

  // ****************************************
  // Second reload checks
  // ****************************************
  a_second_high_b: assert property (
    @(posedge core_clk) disable iff (rst)
    second_load_s |=> second_reload_value[DATA_W-1:HI_LSB]
      == $past(reg_b))
    else $error("second reload high nibble wrong");
  a_second_low_acc: assert property (
    @(posedge core_clk) disable iff (rst)
    second_load_s |=> second_reload_value[HI_LSB-1:0]
      == $past(acc))
    else $error("second reload low nibble wrong");
  a_second_twice: assert property (
    @(posedge core_clk) disable iff (rst)
    second_twice_s |=> second_reload_value == {$past(reg_b), $past(acc)})
    else $error("second of two back-to-back loads lost");
  a_timer_kept: assert property (
    @(posedge core_clk) disable iff (rst)
    only_second_s |=> $stable(timer_count))
    else $error("timer changed on second reload load");
  a_second_keeps_r1: assert property (
    @(posedge core_clk) disable iff (rst)
    only_second_s |=> $stable(first_reload_value))
    else $error("second reload load changed the first reload value");
  a_no_skip_carry: assert property (
    @(posedge core_clk) disable iff (rst)
    second_load_s |-> !skip_next && !carry_write ##1 !skip_next)
    else $error("second reload load touched carry or skip");

  // ****************************************
  // Simultaneous loads
  // ****************************************
  // Both strobes together are legal; with disjoint targets every register
  // ends up holding the same assembled word.
  a_both_loads: assert property (
    @(posedge core_clk) disable iff (rst)
    both_loads_s |=> timer_count == second_reload_value
      && first_reload_value == second_reload_value)
    else $error("simultaneous loads disagree");

  // ****************************************
  // Timing checks
  // ****************************************
  // Done is the core's cue that the single cycle is over; a stale done
  // would let it retire an instruction that never ran.
  a_one_cycle_done: assert property (
    @(posedge core_clk) disable iff (rst)
    (second_load_s or first_load_s) |-> ##LOAD_CYCLES load_done)
    else $error("load did not finish in one cycle");
  a_done_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    idle_enabled_s |=> !load_done)
    else $error("done raised without a load");
  a_done_from_load: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(load_done) |-> $past(do_first) || $past(do_second))
    else $error("done rose without a load");

  // ****************************************
  // Hold checks
  // ****************************************
  // Registers move only on their own load; the enable freezes everything,
  // the done flag included, so a stalled core sees no change.
  a_timer_only_first: assert property (
    @(posedge core_clk) disable iff (rst)
    !(clk_en && load_timer_and_first_reload) |=> $stable(timer_count))
    else $error("timer moved without a combined load");
  a_r1_only_first: assert property (
    @(posedge core_clk) disable iff (rst)
    !(clk_en && load_timer_and_first_reload)
      |=> $stable(first_reload_value))
    else $error("first reload moved without a combined load");
  a_r2_only_second: assert property (
    @(posedge core_clk) disable iff (rst)
    !(clk_en && load_second_reload) |=> $stable(second_reload_value))
    else $error("second reload moved without its load");
  a_idle_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(second_reload_value) && $stable(first_reload_value))
    else $error("state moved while clock enable low");
  a_freeze_timer: assert property (
    @(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(timer_count) && $stable(load_done))
    else $error("timer or done moved while clock enable low");

  // ****************************************
  // Reset checks
  // ****************************************
  // Checked one edge late: before the first edge the registers are unset.
  a_reset_clears: assert property (
    @(posedge core_clk)
    rst |=> timer_count == RST_VALUE && first_reload_value == RST_VALUE
      && second_reload_value == RST_VALUE && !load_done)
    else $error("reset left a register set");

endmodule

// *** rtl/tmr_load_pkg.sv ***
// Constants shared by the timer load path.
// Assumes a host core that decodes the load instructions for us.
package tmr_load_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int HI_LSB = 4;
  localparam logic [7:0] RST_VALUE = 8'h00;
  localparam int LOAD_CYCLES = 1;
endpackage
